//--- hw/memio_cfg.svh
// Constants for the memory and port array.
`ifndef MEMIO_CFG_SVH
`define MEMIO_CFG_SVH
`define REG_PORTA_DATA 2'h0
`define REG_PORTA_DIR 2'h1
`define REG_PORTB_DATA 2'h2
`define REG_PORTB_DIR 2'h3
`define PORT_RESET_VAL 8'h00
`define ROM_DEPTH 1024
`define RAM_DEPTH 64
`define ADDR_IO_SEL_BIT 2
`define ADDR_IRQ_EN_BIT 3
`define IRQ_PIN_BIT 7
`define CS1_PIN_BIT 5
`define CS2_PIN_BIT 6
`endif

//--- hw/memio_pkg.sv
// Types for the memory and port array.
package memio_pkg;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_ROM = 2'b01,
		SEL_RAM = 2'b10,
		SEL_IO = 2'b11
	} region_t;
	typedef logic [7:0] byte_t;
endpackage

//--- hw/port_if.sv
// Interface between the array core and one peripheral port.
interface port_if;
	logic wrData;
	logic wrDir;
	logic [7:0] wdata;
	logic [7:0] dataReg;
	logic [7:0] dirReg;
	logic [7:0] readVal;
	modport core(output wrData, output wrDir, output wdata, input dataReg, input dirReg, input readVal);
	modport port(input wrData, input wrDir, input wdata, output dataReg, output dirReg, output readVal);
endinterface

//--- hw/io_port.sv
// One 8-bit peripheral port with data and direction registers.
`include "memio_cfg.svh"
module io_port
	import memio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] pinIn,
	port_if.port bus
);
	byte_t data_ff;
	byte_t dir_ff;
	byte_t nxt_data;
	byte_t nxt_dir;
	byte_t rdVal;
	// -----------------------------------------------------------------
	// Register update
	// -----------------------------------------------------------------
	always_comb begin
		nxt_data = data_ff;
		nxt_dir = dir_ff;
		if (bus.wrData) begin
			nxt_data = bus.wdata;
		end
		if (bus.wrDir) begin
			nxt_dir = bus.wdata;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			data_ff <= `PORT_RESET_VAL;
			dir_ff <= `PORT_RESET_VAL;
		end else begin
			data_ff <= nxt_data;
			dir_ff <= nxt_dir;
		end
	end
	// -----------------------------------------------------------------
	// Read path
	// -----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// inputs read the pin, outputs read the register.
			assign rdVal[i] = dir_ff[i] ? data_ff[i] : pinIn[i];
		end
	endgenerate
	assign bus.dataReg = data_ff;
	assign bus.dirReg = dir_ff;
	assign bus.readVal = rdVal;
	a_reset_clears: assert property (@(posedge sys_clk) reset |=> (data_ff == 8'h00 && dir_ff == 8'h00))
		else $error("port registers not cleared");
	a_data_hold: assert property (@(posedge sys_clk) disable iff (reset) !bus.wrData |=> data_ff == $past(data_ff))
		else $error("data register changed without write");
endmodule

//--- hw/rom_ram_io_port_array.sv
// Top of the memory and port array: decode, ROM, RAM, ports and pin drive.
`include "memio_cfg.svh"
module rom_ram_io_port_array
	import memio_pkg::*;
#(
	parameter bit CS1_IS_SELECT = 1'b0,
	parameter bit CS2_IS_SELECT = 1'b0,
	parameter bit CS1_MATCH = 1'b1,
	parameter bit CS2_MATCH = 1'b1,
	parameter bit IRQ_PULLUP = 1'b1,
	parameter logic [1023:0][7:0] ROM_IMAGE = '0
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [9:0] addrLines,
	input wire logic romRegionSelect,
	input wire logic rdNotWr,
	input wire logic phi2,
	input wire logic [7:0] busDataIn,
	output logic [7:0] busDataOut,
	output logic busDataOen_n,
	input wire logic [7:0] portAIn,
	output logic [7:0] portAOut,
	output logic [7:0] portAOen_n,
	output logic [7:0] portAPullup,
	input wire logic [7:0] portBIn,
	output logic [7:0] portBOut,
	output logic [7:0] portBOen_n,
	output logic [7:0] portBPullup,
	input wire logic timerEvent,
	input wire logic timerIrqClear
);
	port_if pa();
	port_if pb();
	byte_t ram_ff [`RAM_DEPTH];
	byte_t nxt_ramWord;
	logic ramWe;
	byte_t dout_ff;
	byte_t nxt_dout;
	logic doen_ff;
	logic nxt_doen;
	logic irqEn_ff;
	logic nxt_irqEn;
	logic irqFlag_ff;
	logic nxt_irqFlag;
	byte_t paOut_ff, paOen_ff, pbOut_ff, pbOen_ff, pbPull_ff;
	byte_t nxt_paOut, nxt_paOen, nxt_pbOut, nxt_pbOen, nxt_pbPull;
	logic csOk;
	region_t region;
	logic access;
	logic regWrite;
	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	always_comb begin
		// a pin kept as port data never gates selection.
		csOk = (!CS1_IS_SELECT || portBIn[`CS1_PIN_BIT] == CS1_MATCH) &&
			(!CS2_IS_SELECT || portBIn[`CS2_PIN_BIT] == CS2_MATCH);
		// region select and lines A9 to A6 decode; A5 to A0 never pick a region.
		// ROM needs region select plus the chip selects.
		// RAM uses A9 low, A7 and A6 high.
		if (!csOk) begin
			region = SEL_NONE;
		end else if (romRegionSelect) begin
			region = SEL_ROM;
		end else if (!addrLines[9] && addrLines[7] && addrLines[6]) begin
			region = SEL_RAM;
		end else if (addrLines[9] && addrLines[8] && addrLines[7] && addrLines[6]) begin
			region = SEL_IO;
		end else begin
			region = SEL_NONE;
		end
		access = phi2 && (region != SEL_NONE) && !reset;
		// low on read/write line is a write.
		// write taken only while phase-two is high.
		regWrite = access && !rdNotWr && region == SEL_IO && addrLines[`ADDR_IO_SEL_BIT];
	end
	// bit 2 high picks ports, bits 1:0 pick the register.
	assign pa.wdata = busDataIn;
	assign pb.wdata = busDataIn;
	assign pa.wrData = regWrite && addrLines[1:0] == `REG_PORTA_DATA;
	assign pa.wrDir = regWrite && addrLines[1:0] == `REG_PORTA_DIR;
	assign pb.wrData = regWrite && addrLines[1:0] == `REG_PORTB_DATA;
	assign pb.wrDir = regWrite && addrLines[1:0] == `REG_PORTB_DIR;
	io_port u_porta (.sys_clk(sys_clk), .reset(reset), .pinIn(portAIn), .bus(pa.port));
	io_port u_portb (.sys_clk(sys_clk), .reset(reset), .pinIn(portBIn), .bus(pb.port));
	// -----------------------------------------------------------------
	// RAM
	// -----------------------------------------------------------------
	// byte index from bits 0 to 5.
	assign ramWe = access && !rdNotWr && region == SEL_RAM;
	assign nxt_ramWord = busDataIn;
	always_ff @(posedge sys_clk) begin
		if (ramWe) begin
			ram_ff[addrLines[5:0]] <= nxt_ramWord;
		end
	end
	// -----------------------------------------------------------------
	// Interrupt enable and flag
	// -----------------------------------------------------------------
	// Timer counting lives elsewhere; only its event and clear reach here.
	always_comb begin
		nxt_irqEn = irqEn_ff;
		nxt_irqFlag = irqFlag_ff;
		if (access && region == SEL_IO && !addrLines[`ADDR_IO_SEL_BIT]) begin
			nxt_irqEn = addrLines[`ADDR_IRQ_EN_BIT];
		end
		if (timerIrqClear) begin
			nxt_irqFlag = 1'b0;
		end
		// The set wins so an event meeting a clear is not lost.
		if (timerEvent) begin
			nxt_irqFlag = 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irqEn_ff <= 1'b0;
			irqFlag_ff <= 1'b0;
		end else begin
			irqEn_ff <= nxt_irqEn;
			irqFlag_ff <= nxt_irqFlag;
		end
	end
	// -----------------------------------------------------------------
	// Data bus read
	// -----------------------------------------------------------------
	always_comb begin
		nxt_dout = dout_ff;
		nxt_doen = 1'b1;
		// drive only during a selected read.
		if (access && rdNotWr) begin
			nxt_doen = 1'b0;
			case (region)
				SEL_ROM: nxt_dout = ROM_IMAGE[addrLines];
				SEL_RAM: nxt_dout = ram_ff[addrLines[5:0]];
				SEL_IO: begin
					if (!addrLines[`ADDR_IO_SEL_BIT]) begin
						nxt_dout = {irqFlag_ff, 7'h00};
					end else begin
						case (addrLines[1:0])
							`REG_PORTA_DATA: nxt_dout = pa.readVal;
							`REG_PORTA_DIR: nxt_dout = pa.dirReg;
							`REG_PORTB_DATA: nxt_dout = pb.readVal;
							default: nxt_dout = pb.dirReg;
						endcase
					end
				end
				default: nxt_doen = 1'b1;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dout_ff <= 8'h00;
			doen_ff <= 1'b1;
		end else begin
			dout_ff <= nxt_dout;
			doen_ff <= nxt_doen;
		end
	end
	// -----------------------------------------------------------------
	// Peripheral pin drive
	// -----------------------------------------------------------------
	always_comb begin
		// each pin steered by its own direction bit.
		// inputs hold the driver high via weak pull-up.
		nxt_paOut = pa.dataReg | ~pa.dirReg;
		nxt_paOen = ~pa.dirReg;
		nxt_pbOut = pb.dataReg | ~pb.dirReg;
		nxt_pbOen = ~pb.dirReg;
		nxt_pbPull = ~pb.dirReg;
		// an input-programmed bit 7 carries the interrupt when enabled.
		// pulled low for a pending interrupt, high otherwise.
		if (!pb.dirReg[`IRQ_PIN_BIT] && irqEn_ff && irqFlag_ff) begin
			nxt_pbOut[`IRQ_PIN_BIT] = 1'b0;
			nxt_pbOen[`IRQ_PIN_BIT] = 1'b0;
		end
		// pull-up on the interrupt pin may be omitted for wire-OR.
		if (!pb.dirReg[`IRQ_PIN_BIT] && irqEn_ff) begin
			nxt_pbPull[`IRQ_PIN_BIT] = IRQ_PULLUP;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			paOut_ff <= 8'hff;
			paOen_ff <= 8'hff;
			pbOut_ff <= 8'hff;
			pbOen_ff <= 8'hff;
			pbPull_ff <= 8'hff;
		end else begin
			paOut_ff <= nxt_paOut;
			paOen_ff <= nxt_paOen;
			pbOut_ff <= nxt_pbOut;
			pbOen_ff <= nxt_pbOen;
			pbPull_ff <= nxt_pbPull;
		end
	end
	assign busDataOut = dout_ff;
	assign busDataOen_n = doen_ff;
	assign portAOut = paOut_ff;
	assign portAOen_n = paOen_ff;
	assign portAPullup = paOen_ff;
	assign portBOut = pbOut_ff;
	assign portBOen_n = pbOen_ff;
	assign portBPullup = pbPull_ff;
	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_reset_bus_off: assert property (@(posedge sys_clk) reset |=> busDataOen_n)
		else $error("data bus driven after reset");
	a_reset_irq_off: assert property (@(posedge sys_clk) reset |=> !irqEn_ff)
		else $error("interrupt enable survived reset");
	a_reset_pins_in: assert property (@(posedge sys_clk) reset ##1 reset |=> (portAOen_n == 8'hff && portBOen_n == 8'hff))
		else $error("pins not inputs after reset");
	a_bus_only_read: assert property (@(posedge sys_clk) disable iff (reset) !busDataOen_n |-> $past(access && rdNotWr))
		else $error("data bus driven outside a read");
	a_irq_pin_low: assert property (@(posedge sys_clk) disable iff (reset)
		(irqEn_ff && irqFlag_ff && !pb.dirReg[7]) |=> (portBOut[7] == 1'b0 && !portBOen_n[7]))
		else $error("interrupt not signalled");
	a_out_follows_reg: assert property (@(posedge sys_clk) disable iff (reset)
		pa.dirReg[0] |=> (portAOut[0] == $past(pa.dataReg[0]) && !portAOen_n[0]))
		else $error("output pin not showing data register");
	a_input_held_high: assert property (@(posedge sys_clk) disable iff (reset)
		!pa.dirReg[3] |=> (portAOut[3] && portAOen_n[3]))
		else $error("input pin driver not high");
	a_read_pin_level: assert property (@(posedge sys_clk) disable iff (reset)
		(access && rdNotWr && region == SEL_IO && addrLines[2:0] == 3'h4) |=> busDataOut == $past(pa.readVal))
		else $error("port read returned wrong value");
	a_write_needs_phi2: assert property (@(posedge sys_clk) disable iff (reset)
		!phi2 |=> ($stable(pa.dataReg) && $stable(pa.dirReg) && $stable(pb.dataReg) && $stable(pb.dirReg)))
		else $error("register write outside phase-two write");
	// -----------------------------------------------------------------
	// Checks against the pins
	// -----------------------------------------------------------------
	// These start from pin levels, so a broken decode cannot excuse itself, except a_out_read_reg and a_irq_en_write,
	// which start from access and region, and a_irq_pullup_opt and a_dir_drives_pin, which start from register state.
	a_rom_read_data: assert property (@(posedge sys_clk) (phi2 && rdNotWr && romRegionSelect && csOk && !reset)
		|=> (!busDataOen_n && busDataOut == ROM_IMAGE[$past(addrLines)]))
		else $error("ROM read returned wrong byte");
	a_cs_blocks_bus: assert property (@(posedge sys_clk) ((CS1_IS_SELECT && portBIn[`CS1_PIN_BIT] != CS1_MATCH) ||
		(CS2_IS_SELECT && portBIn[`CS2_PIN_BIT] != CS2_MATCH)) |=> busDataOen_n)
		else $error("bus driven with chip select off");
	a_ram_write_hit: assert property (@(posedge sys_clk) (phi2 && !rdNotWr && !romRegionSelect && csOk && !reset &&
		!addrLines[9] && addrLines[7:6] == 2'b11) |=> ram_ff[$past(addrLines[5:0])] == $past(busDataIn))
		else $error("RAM byte not written");
	a_irq_pullup_opt: assert property (@(posedge sys_clk) disable iff (reset)
		(irqEn_ff && !pb.dirReg[`IRQ_PIN_BIT]) |=> portBPullup[`IRQ_PIN_BIT] == IRQ_PULLUP)
		else $error("interrupt pin pull-up option ignored");
	a_dir_drives_pin: assert property (@(posedge sys_clk) disable iff (reset)
		pb.dirReg[2] |=> (!portBOen_n[2] && portBOut[2] == $past(pb.dataReg[2])))
		else $error("output direction not driving pin");
	a_out_read_reg: assert property (@(posedge sys_clk) (access && rdNotWr && region == SEL_IO &&
		addrLines[2:0] == 3'h6 && pb.dirReg[4]) |=> busDataOut[4] == $past(pb.dataReg[4]))
		else $error("output bit read did not return register");
	a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (reset) timerEvent |=> irqFlag_ff)
		else $error("timer event lost");
	a_irq_en_write: assert property (@(posedge sys_clk) disable iff (reset) (access && region == SEL_IO &&
		!addrLines[`ADDR_IO_SEL_BIT]) |=> irqEn_ff == $past(addrLines[`ADDR_IRQ_EN_BIT]))
		else $error("interrupt enable not taken from address");
	a_no_strobe_off: assert property (@(posedge sys_clk) disable iff (reset) !phi2 |=> busDataOen_n)
		else $error("data bus driven without strobe");
	a_pins_reset_high: assert property (@(posedge sys_clk) reset |=> (portAOut == 8'hff && portBOut == 8'hff))
		else $error("pins not held high after reset");
	c_port_write: cover property (@(posedge sys_clk) pa.wrData);
	c_ram_read: cover property (@(posedge sys_clk) access && rdNotWr && region == SEL_RAM);
	c_rom_read: cover property (@(posedge sys_clk) access && rdNotWr && region == SEL_ROM);
	c_irq_seen: cover property (@(posedge sys_clk) !portBOen_n[7] && !portBOut[7] && !pb.dirReg[7]);
	c_cs_refused: cover property (@(posedge sys_clk) phi2 && !csOk);
endmodule

//--- dv/cpu_model.sv
// Host processor model that runs single bus cycles on the shared bus.
module cpu_model
	import memio_pkg::*;
(
	input wire logic sys_clk,
	output logic [9:0] addrLines,
	output logic romRegionSelect,
	output logic rdNotWr,
	output logic phi2,
	output logic [7:0] busDataIn,
	input wire logic [7:0] busDataOut,
	input wire logic busDataOen_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		addrLines = 10'h000;
		romRegionSelect = 1'b0;
		rdNotWr = 1'b1;
		phi2 = 1'b0;
		busDataIn = 8'h00;
	end

	// ----------------------------------------
	// Bus cycle
	// ----------------------------------------
	// Idle data is inverted so a stale byte is never taken as a write.
	// read high, write low.
	task automatic access(input logic rd, input logic rs, input logic [9:0] a, input byte_t d, output byte_t q,
		output logic oen);
		@(posedge sys_clk);
		#1;
		addrLines = a;
		romRegionSelect = rs;
		rdNotWr = rd;
		busDataIn = rd ? ~d : d;
		phi2 = 1'b1;
		@(posedge sys_clk);
		#1;
		q = busDataOut;
		oen = busDataOen_n;
		phi2 = 1'b0;
		rdNotWr = 1'b1;
		busDataIn = ~busDataIn;
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking testbench for the memory and port array.
`include "memio_cfg.svh"
module tb_top
	import memio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	function automatic logic [1023:0][7:0] romFill();
		logic [1023:0][7:0] img;
		for (int i = 0; i < `ROM_DEPTH; i++) img[i] = 8'(i * 7 + 3);
		return img;
	endfunction

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic timerEvent = 1'b0;
	logic timerIrqClear = 1'b0;
	logic [7:0] portAIn = 8'hff;
	logic [7:0] portBIn = 8'hff;
	logic [9:0] addrLines;
	logic romRegionSelect, rdNotWr, phi2, busDataOen_n;
	logic [7:0] busDataIn, busDataOut;
	logic [7:0] portAOut, portAOen_n, portAPullup, portBOut, portBOen_n, portBPullup;
	int err_count = 0;
	int comparisons = 0;
	byte_t q, da, ra, db, rb, d;
	logic o;
	logic [9:0] a;

	always #2.5 sys_clk = ~sys_clk;

	cpu_model cpu_model_inst (.sys_clk(sys_clk), .addrLines(addrLines), .romRegionSelect(romRegionSelect),
		.rdNotWr(rdNotWr), .phi2(phi2), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOen_n(busDataOen_n));

	rom_ram_io_port_array #(.CS1_IS_SELECT(1'b1), .ROM_IMAGE(romFill())) rom_ram_io_port_array_inst (.sys_clk(sys_clk),
		.reset(reset),
		.addrLines(addrLines), .romRegionSelect(romRegionSelect), .rdNotWr(rdNotWr), .phi2(phi2),
		.busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOen_n(busDataOen_n), .portAIn(portAIn),
		.portAOut(portAOut), .portAOen_n(portAOen_n), .portAPullup(portAPullup), .portBIn(portBIn),
		.portBOut(portBOut), .portBOen_n(portBOen_n), .portBPullup(portBPullup), .timerEvent(timerEvent),
		.timerIrqClear(timerIrqClear));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic rs, input logic [9:0] wa, input byte_t wd);
		cpu_model_inst.access(1'b0, rs, wa, wd, q, o);
	endtask

	task automatic rd(input logic rs, input logic [9:0] ra2, input byte_t exp);
		cpu_model_inst.access(1'b1, rs, ra2, 8'h00, q, o);
		chk({7'h00, o}, 8'h00);
		chk(q, exp);
	endtask

	task automatic pins(input byte_t dir, input byte_t dat, input byte_t oen, input byte_t out, input byte_t pu);
		chk(oen, ~dir);
		chk(out, dat | ~dir);
		chk(pu, ~dir);
	endtask

	// Pulses one timer input, then lets the flag reach the pin.
	task automatic pulse(input logic clr, input logic expOen);
		@(posedge sys_clk);
		#1;
		if (clr) timerIrqClear = 1'b1; else timerEvent = 1'b1;
		@(posedge sys_clk);
		#1;
		timerIrqClear = 1'b0;
		timerEvent = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk({7'h00, portBOen_n[7]}, {7'h00, expOen});
		if (!expOen) chk({7'h00, portBOut[7]}, 8'h00);
	endtask

	task automatic stop_test();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		err_count++;
		stop_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h99621da0));
		repeat (12) @(posedge sys_clk);
		#1;
		chk({7'h00, busDataOen_n}, 8'h01);
		pins(8'h00, 8'h00, portAOen_n, portAOut, portAPullup);
		pins(8'h00, 8'h00, portBOen_n, portBOut, portBPullup);
		reset = 1'b0;
		for (int n = 0; n < 16; n++) begin
			{da, ra, db, rb} = $urandom;
			// bit 7 of port B stays an input.
			rb[7] = 1'b0;
			portAIn = 8'($urandom);
			// Bit 5 is a chip select in this build, so it must match for the port to answer.
			portBIn = 8'($urandom) | 8'h20;
			wr(1'b0, 10'h3c4 | 10'(`REG_PORTA_DATA), da);
			wr(1'b0, 10'h3c4 | 10'(`REG_PORTA_DIR), ra);
			wr(1'b0, 10'h3c4 | 10'(`REG_PORTB_DATA), db);
			wr(1'b0, 10'h3c4 | 10'(`REG_PORTB_DIR), rb);
			rd(1'b0, 10'h3c4 | 10'(`REG_PORTA_DATA), (ra & da) | (~ra & portAIn));
			rd(1'b0, 10'h3c4 | 10'(`REG_PORTB_DATA), (rb & db) | (~rb & portBIn));
			rd(1'b0, 10'h3c4 | 10'(`REG_PORTA_DATA), (ra & da) | (~ra & portAIn));
			pins(ra, da, portAOen_n, portAOut, portAPullup);
			pins(rb, db, portBOen_n, portBOut, portBPullup);
			a = {1'b0, 1'($urandom), 2'b11, 6'($urandom)};
			d = 8'($urandom);
			wr(1'b0, a, d);
			rd(1'b0, a, d);
			a = 10'($urandom);
			rd(1'b1, a, 8'(a * 7 + 3));
			cpu_model_inst.access(1'b1, 1'b0, {1'b0, 1'($urandom), 2'b00, 6'($urandom)}, 8'h00, q, o);
			chk({7'h00, o}, 8'h01);
		end
		portBIn[`CS1_PIN_BIT] = 1'b0;
		cpu_model_inst.access(1'b1, 1'b1, 10'h000, 8'h00, q, o);
		chk({7'h00, o}, 8'h01);
		portBIn[`CS1_PIN_BIT] = 1'b1;
		wr(1'b0, 10'h3c4 | 10'(`REG_PORTB_DIR), 8'h00);
		wr(1'b0, 10'h3c8, 8'h00);
		pulse(1'b0, 1'b0);
		rd(1'b0, 10'h3c8, 8'h80);
		pulse(1'b1, 1'b1);
		wr(1'b0, 10'h3c0, 8'h00);
		pulse(1'b0, 1'b1);
		pulse(1'b1, 1'b1);
		wr(1'b0, 10'h3c8, 8'h00);
		@(posedge sys_clk);
		#1;
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		chk({7'h00, busDataOen_n}, 8'h01);
		pins(8'h00, 8'h00, portAOen_n, portAOut, portAPullup);
		pulse(1'b0, 1'b1);
		stop_test();
	end
endmodule
